/* File: clk_ratio_pkg.sv */
package clk_ratio_pkg;

  // --------------------------------------------------------------------------
  // frequency control register layout
  // --------------------------------------------------------------------------
  localparam logic [15:0] FREQ_CTRL_RESET = 16'h0102; // power-on value
  localparam logic [15:0] FREQ_CTRL_WMASK = 16'h03ff; // writable bits
  localparam int PLL_EN_BIT = 7;       // first pll on/off
  localparam int MULT_LSB = 4;         // multiplier field low bit
  localparam int CORE_DIV_LSB = 2;     // core divider field low bit
  localparam int PERIPH_DIV_LSB = 0;   // peripheral divider field low bit

  // two-bit ratio codes, shared by multiplier and divider fields
  localparam logic [1:0] CODE_X1 = 2'h0;
  localparam logic [1:0] CODE_X2 = 2'h1;   // x2 or 1/2
  localparam logic [1:0] CODE_X4 = 2'h2;   // x4 or 1/4
  localparam logic [1:0] CODE_BAD = 2'h3;  // prohibited

  // shift amounts of the ratios (log2)
  localparam logic [1:0] SHIFT_0 = 2'h0;
  localparam logic [1:0] SHIFT_1 = 2'h1;
  localparam logic [1:0] SHIFT_2 = 2'h2;

  // --------------------------------------------------------------------------
  // clock operating modes and divider sources
  // --------------------------------------------------------------------------
  localparam logic [2:0] MODE_LAST_PLL_FORCED = 3'h2; // modes 0-2
  localparam logic [2:0] MODE_SECONDARY_PLL_LAST = 3'h4;        // modes 3,4
  localparam logic [2:0] MODE_DIV3 = 3'h5;             // mode 5

  typedef enum logic [1:0] {
    SRC_MAIN_PLL = 2'b00,
    SRC_SECONDARY_PLL = 2'b01,
    SRC_PLL_32K = 2'b10,
    SRC_DIV3 = 2'b11
  } src_sel_t;

  // ratio summary: exponents relative to the bus clock pin
  typedef struct packed {
    logic signed [3:0] core_exp;   // log2(internal / bus clock)
    logic signed [3:0] periph_exp; // log2(peripheral / bus clock)
    logic [1:0] mult_shift;        // log2 of pll multiplier
    logic [1:0] core_div_shift;    // log2 of divider 1 reduction
    logic [1:0] periph_div_shift;  // log2 of divider 2 reduction
  } ratio_t;

endpackage

/* File: clock_ratio_generator.sv */
// Overview of operation
// RL1: modes 3-7: first pll follows register enable
// RL2: power-on reset turns first pll off
// RL3: software turns pll off before standby
// RL4: divider 1 source: main_multiplier_pll, else secondary_pll, else 32k; with 32k also off the code selects the div3 path
// RL5: divider 2 source chosen by clock mode
// RL6: pll on: core = bus x mult x div1
// RL7: pll off: core equals bus clock
// RL8: software keeps core not below bus clock
// RL9: modes 0-2: periph = bus x mult x div2
// RL10: modes 3-7: periph = bus x div2
// RL11: software bounds periph clock frequency
// RL12: software keeps pll output at most 60 mhz
// RL13: multipliers 1,2,4; divider ratios 1,1/2,1/4
// RL14: power-on loads 0x0102; manual reset keeps
// RL15: multiplier codes 00 x1, 01 x2, 10 x4
// RL16: divider codes 00 1, 01 1/2, 10 1/4
module clock_ratio_generator (
  input wire logic sys_clk,
  input wire logic rst,                    // power-on reset
  input wire logic manual_reset,           // register holds its value
  input wire logic [2:0] clock_mode,       // mode pins
  input wire logic secondary_pll_on,
  input wire logic pll_32k_on,
  input wire logic reg_wr,                 // word write strobe
  input wire logic [15:0] reg_wdata,
  output logic [15:0] freq_control_reg,    // register readback
  output logic main_multiplier_pll_on,
  output clk_ratio_pkg::src_sel_t div1_src,
  output clk_ratio_pkg::src_sel_t div2_src,
  output clk_ratio_pkg::ratio_t ratio,
  output logic setting_error               // prohibited code held
);

  // --------------------------------------------------------------------------
  // field decode
  // --------------------------------------------------------------------------
  logic [15:0] freq_control_r;
  logic [15:0] freq_control_nxt;
  logic [1:0] multiplier_field;     // pll multiplier code
  logic [1:0] core_divider_field;   // divider 1 code
  logic [1:0] periph_divider_field; // divider 2 code
  logic forced_mode;                // modes 0-2 keep the pll running
  logic pll_on_nxt;
  clk_ratio_pkg::src_sel_t div1_nxt;
  clk_ratio_pkg::src_sel_t div2_nxt;
  clk_ratio_pkg::ratio_t ratio_nxt;
  logic err_nxt;

  assign multiplier_field =
    freq_control_r[clk_ratio_pkg::MULT_LSB +: 2];
  assign core_divider_field =
    freq_control_r[clk_ratio_pkg::CORE_DIV_LSB +: 2];
  assign periph_divider_field =
    freq_control_r[clk_ratio_pkg::PERIPH_DIV_LSB +: 2];
  assign forced_mode = clock_mode <= clk_ratio_pkg::MODE_LAST_PLL_FORCED;

  // code to shift; prohibited code falls back to x1 so clocks stay sane
  function automatic logic [1:0] code_shift(input logic [1:0] code);
    case (code)
      clk_ratio_pkg::CODE_X1: code_shift = clk_ratio_pkg::SHIFT_0;
      clk_ratio_pkg::CODE_X2: code_shift = clk_ratio_pkg::SHIFT_1; // see RL15
      clk_ratio_pkg::CODE_X4: code_shift = clk_ratio_pkg::SHIFT_2; // see RL16
      default: code_shift = clk_ratio_pkg::SHIFT_0;
    endcase
  endfunction

  // --------------------------------------------------------------------------
  // frequency control register
  // --------------------------------------------------------------------------
  // manual reset and standby leave the contents alone; only rst reloads
  always_comb
  begin
    freq_control_nxt = freq_control_r;
    if (reg_wr && !manual_reset)
    begin
      freq_control_nxt = reg_wdata & clk_ratio_pkg::FREQ_CTRL_WMASK;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      freq_control_r <= clk_ratio_pkg::FREQ_CTRL_RESET; // see RL14, RL2
    else
      freq_control_r <= freq_control_nxt;
  end

  // --------------------------------------------------------------------------
  // pll enable and source selection
  // --------------------------------------------------------------------------
  always_comb
  begin
    // modes 0-2 run the pll regardless of the enable bit
    pll_on_nxt = forced_mode ||
      freq_control_r[clk_ratio_pkg::PLL_EN_BIT]; // see RL1
    // divider 1 priority: first pll, secondary pll, 32k pll
    if (pll_on_nxt)
      div1_nxt = clk_ratio_pkg::SRC_MAIN_PLL; // see RL4
    else if (secondary_pll_on)
      div1_nxt = clk_ratio_pkg::SRC_SECONDARY_PLL;
    else if (pll_32k_on)
      div1_nxt = clk_ratio_pkg::SRC_PLL_32K;
    else
      div1_nxt = clk_ratio_pkg::SRC_DIV3; // nothing running: bypass path
    // divider 2 follows the mode alone
    if (forced_mode)
      div2_nxt = clk_ratio_pkg::SRC_MAIN_PLL; // see RL5
    else if (clock_mode <= clk_ratio_pkg::MODE_SECONDARY_PLL_LAST)
      div2_nxt = clk_ratio_pkg::SRC_SECONDARY_PLL;
    else if (clock_mode == clk_ratio_pkg::MODE_DIV3)
      div2_nxt = clk_ratio_pkg::SRC_DIV3;
    else
      div2_nxt = clk_ratio_pkg::SRC_PLL_32K;
  end

  // --------------------------------------------------------------------------
  // ratio computation, as log2 exponents against the bus clock pin
  // --------------------------------------------------------------------------
  always_comb
  begin
    ratio_nxt.mult_shift = code_shift(multiplier_field); // see RL13
    ratio_nxt.core_div_shift = code_shift(core_divider_field);
    ratio_nxt.periph_div_shift = code_shift(periph_divider_field);
    if (pll_on_nxt)
      ratio_nxt.core_exp = 4'(signed'({2'h0, ratio_nxt.mult_shift}))
        - 4'(signed'({2'h0, ratio_nxt.core_div_shift})); // see RL6
    else
      ratio_nxt.core_exp = 4'sh0; // see RL7
    if (forced_mode)
      ratio_nxt.periph_exp = 4'(signed'({2'h0, ratio_nxt.mult_shift}))
        - 4'(signed'({2'h0, ratio_nxt.periph_div_shift})); // see RL9
    else
      ratio_nxt.periph_exp =
        -4'(signed'({2'h0, ratio_nxt.periph_div_shift})); // see RL10
    // flag prohibited codes; bounds of RL8, RL11, RL12 are software's
    err_nxt = (multiplier_field == clk_ratio_pkg::CODE_BAD) ||
      (core_divider_field == clk_ratio_pkg::CODE_BAD) ||
      (periph_divider_field == clk_ratio_pkg::CODE_BAD);
  end

  // --------------------------------------------------------------------------
  // registered outputs
  // --------------------------------------------------------------------------
  // outputs lag the register by one cycle; clocks settle far slower anyway
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      freq_control_reg <= clk_ratio_pkg::FREQ_CTRL_RESET;
      main_multiplier_pll_on <= 1'b0; // see RL2
      div1_src <= clk_ratio_pkg::SRC_MAIN_PLL;
      div2_src <= clk_ratio_pkg::SRC_MAIN_PLL;
      ratio <= '0;
      setting_error <= 1'b0;
    end
    else
    begin
      freq_control_reg <= freq_control_r;
      main_multiplier_pll_on <= pll_on_nxt;
      div1_src <= div1_nxt;
      div2_src <= div2_nxt;
      ratio <= ratio_nxt;
      setting_error <= err_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  // an accepted write: strobe high while manual reset is low
  sequence wr_seq;
    reg_wr && !manual_reset;
  endsequence

  // modes 3-7 held for two samples, so only the enable bit decides
  sequence mode_steady_seq;
    clock_mode > clk_ratio_pkg::MODE_LAST_PLL_FORCED ##1 $stable(clock_mode);
  endsequence

  // second sample after power-on reset ends, with modes 3-7 in force;
  // the first sample still shows the reset values, so it proves nothing
  sequence por_left_seq;
    $past(rst, 2) && !$past(rst) &&
    $past(clock_mode) > clk_ratio_pkg::MODE_LAST_PLL_FORCED;
  endsequence

  pll_follow_a: assert property ( // see RL1
    @(posedge sys_clk) disable iff (rst)
    mode_steady_seq |=> main_multiplier_pll_on ==
    $past(freq_control_r[clk_ratio_pkg::PLL_EN_BIT]))
    else $error("pll enable not followed");
  por_pll_off_a: assert property ( // see RL2
    @(posedge sys_clk) disable iff (rst)
    por_left_seq |-> !main_multiplier_pll_on)
    else $error("pll on after power-on reset");
  wr_load_a: assert property ( // see RL14
    @(posedge sys_clk) disable iff (rst)
    wr_seq |=> ##1 freq_control_reg ==
    ($past(reg_wdata, 2) & clk_ratio_pkg::FREQ_CTRL_WMASK))
    else $error("register write lost");
  manual_hold_a: assert property ( // see RL14
    @(posedge sys_clk) disable iff (rst)
    manual_reset |=> $stable(freq_control_r))
    else $error("manual reset changed register");
  div1_main_a: assert property ( // see RL4
    @(posedge sys_clk) disable iff (rst)
    main_multiplier_pll_on |-> div1_src == clk_ratio_pkg::SRC_MAIN_PLL)
    else $error("divider 1 source wrong");
  // the first sample after release still shows the reset values
  div2_forced_a: assert property ( // see RL5
    @(posedge sys_clk) disable iff (rst)
    !$past(rst) && $past(clock_mode) <= clk_ratio_pkg::MODE_LAST_PLL_FORCED
    |-> div2_src == clk_ratio_pkg::SRC_MAIN_PLL && main_multiplier_pll_on)
    else $error("modes 0-2 source wrong");
  core_off_a: assert property ( // see RL7
    @(posedge sys_clk) disable iff (rst)
    !main_multiplier_pll_on |-> ratio.core_exp == 4'sh0)
    else $error("core not at bus rate");
  core_on_a: assert property ( // see RL6
    @(posedge sys_clk) disable iff (rst)
    main_multiplier_pll_on |-> ratio.core_exp ==
    4'(signed'({2'h0, ratio.mult_shift}))
    - 4'(signed'({2'h0, ratio.core_div_shift})))
    else $error("core ratio wrong");
  periph_forced_a: assert property ( // see RL9
    @(posedge sys_clk) disable iff (rst)
    !$past(rst) && $past(clock_mode) <= clk_ratio_pkg::MODE_LAST_PLL_FORCED
    |-> ratio.periph_exp == 4'(signed'({2'h0, ratio.mult_shift}))
    - 4'(signed'({2'h0, ratio.periph_div_shift})))
    else $error("modes 0-2 periph ratio wrong");
  periph_ratio_a: assert property ( // see RL10
    @(posedge sys_clk) disable iff (rst)
    $past(clock_mode) > clk_ratio_pkg::MODE_LAST_PLL_FORCED |->
    ratio.periph_exp == -4'(signed'({2'h0, ratio.periph_div_shift})))
    else $error("periph ratio wrong");
  mult_code_a: assert property ( // see RL15
    @(posedge sys_clk) disable iff (rst)
    $past(multiplier_field) == clk_ratio_pkg::CODE_X4 |->
    ratio.mult_shift == clk_ratio_pkg::SHIFT_2)
    else $error("multiplier decode wrong");
  core_code_a: assert property ( // see RL16
    @(posedge sys_clk) disable iff (rst)
    $past(core_divider_field) == clk_ratio_pkg::CODE_X4 |->
    ratio.core_div_shift == clk_ratio_pkg::SHIFT_2)
    else $error("core divider decode wrong");
  // a prohibited multiplier code must raise the flag and fall back to x1
  bad_code_a: assert property ( // see RL15
    @(posedge sys_clk) disable iff (rst)
    $past(multiplier_field) == clk_ratio_pkg::CODE_BAD |->
    setting_error && ratio.mult_shift == clk_ratio_pkg::SHIFT_0)
    else $error("prohibited multiplier not flagged");

endmodule // clock_ratio_generator

/* File: clock_ratio_generator_tb.sv */
module clock_ratio_generator_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // --------------------------------------------------------------------------
  // stimulus and observed signals
  // --------------------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic rst = 1'b1; // power-on reset held from time zero
  logic manual_reset = 1'b0;
  logic [2:0] clock_mode = 3'h3;
  logic secondary_pll_on = 1'b0;
  logic pll_32k_on = 1'b0;
  logic reg_wr = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] freq_control_reg;
  logic main_multiplier_pll_on;
  clk_ratio_pkg::src_sel_t div1_src;
  clk_ratio_pkg::src_sel_t div2_src;
  clk_ratio_pkg::ratio_t ratio;
  logic setting_error;
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0; // hang guard, far above the few hundred cycles needed
  // one word per code of every field, plus prohibited codes and high bits;
  // legal words keep core >= bus and periph within bus and core/4 in every
  // mode, and a x4 pll only ever on a slow bus clock
  logic [15:0] vals [7] = '{16'h0102, 16'h01d1, 16'h01ea, 16'h0126,
                            16'h0030, 16'hffff, 16'h0100};

  always #12.5 sys_clk = ~sys_clk;

  clock_ratio_generator uut (
    .sys_clk(sys_clk), .rst(rst), .manual_reset(manual_reset),
    .clock_mode(clock_mode), .secondary_pll_on(secondary_pll_on),
    .pll_32k_on(pll_32k_on), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .freq_control_reg(freq_control_reg),
    .main_multiplier_pll_on(main_multiplier_pll_on),
    .div1_src(div1_src), .div2_src(div2_src), .ratio(ratio),
    .setting_error(setting_error)
  );

  // --------------------------------------------------------------------------
  // checking helpers
  // --------------------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // prohibited code reads as x1
  function automatic logic [1:0] dec(input logic [1:0] c);
    return (c == 2'h3) ? 2'h0 : c;
  endfunction

  // expected outputs worked out from the stored word and the mode inputs
  task automatic verify(input logic [15:0] val);
    logic [15:0] r;
    logic on;
    logic lo_mode;
    clk_ratio_pkg::ratio_t e;
    clk_ratio_pkg::src_sel_t s1;
    clk_ratio_pkg::src_sel_t s2;
    r = val & 16'h03ff;
    lo_mode = (clock_mode <= 3'h2);
    on = lo_mode | r[7];
    e.mult_shift = dec(r[5:4]);
    e.core_div_shift = dec(r[3:2]);
    e.periph_div_shift = dec(r[1:0]);
    e.core_exp = on ? 4'(int'(e.mult_shift) - int'(e.core_div_shift)) : 4'h0;
    e.periph_exp = 4'(int'(lo_mode ? e.mult_shift : 2'h0)
                      - int'(e.periph_div_shift));
    // pll off: second pll first, then 32k, else the div3 path feeds divider 1
    s1 = on ? clk_ratio_pkg::SRC_MAIN_PLL :
         secondary_pll_on ? clk_ratio_pkg::SRC_SECONDARY_PLL :
         pll_32k_on ? clk_ratio_pkg::SRC_PLL_32K : clk_ratio_pkg::SRC_DIV3;
    s2 = lo_mode ? clk_ratio_pkg::SRC_MAIN_PLL :
         (clock_mode <= 3'h4) ? clk_ratio_pkg::SRC_SECONDARY_PLL :
         (clock_mode == 3'h5) ? clk_ratio_pkg::SRC_DIV3 :
         clk_ratio_pkg::SRC_PLL_32K;
    chk("freq_control_reg", freq_control_reg, r);
    chk("pll_on", {15'h0, main_multiplier_pll_on}, {15'h0, on});
    chk("div1_src", {14'h0, div1_src}, {14'h0, s1});
    chk("div2_src", {14'h0, div2_src}, {14'h0, s2});
    chk("ratio", {2'h0, ratio}, {2'h0, e});
    chk("setting_error", {15'h0, setting_error},
        {15'h0, (&r[5:4]) | (&r[3:2]) | (&r[1:0])});
  endtask

  // one or two back-to-back word writes; returns at the last taking edge
  task automatic wr(input logic [15:0] a, input logic [15:0] b, input bit two);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_wdata <= a;
    if (two)
    begin
      @(posedge sys_clk);
      reg_wdata <= b;
    end
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic settle();
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  // --------------------------------------------------------------------------
  // hang guard and main sequence
  // --------------------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_total++;
      stop_test();
    end
  end

  initial
  begin
    repeat (20) @(posedge sys_clk);
    #1;
    chk("reset reg", freq_control_reg, 16'h0102);
    chk("reset pll", {15'h0, main_multiplier_pll_on}, 16'h0000);
    @(posedge sys_clk);
    rst <= 1'b0;
    settle();
    verify(16'h0102);
    // every mode; modes 3, 5 and 6 each with a different mix of the other pll states, the rest with both off
    for (int m = 0; m < 8; m++)
    begin
      @(posedge sys_clk);
      clock_mode <= 3'(m);
      secondary_pll_on <= (m == 3) || (m == 5);
      pll_32k_on <= (m == 3) || (m == 6);
      foreach (vals[i])
      begin
        wr(vals[i], 16'h0000, 1'b0);
        settle();
        verify(vals[i]);
      end
    end
    // manual reset keeps the register; writes meanwhile are dropped
    @(posedge sys_clk);
    manual_reset <= 1'b1;
    wr(16'h01e0, 16'h0000, 1'b0);
    settle();
    verify(16'h0100);
    @(posedge sys_clk);
    manual_reset <= 1'b0;
    wr(16'h0111, 16'h01d6, 1'b1);
    settle();
    verify(16'h01d6);
    // second power-on reset in mid-run, mode 7, pll had been on;
    // standby is never entered, so the pll-off duty never arises
    @(posedge sys_clk);
    rst <= 1'b1;
    #1;
    chk("rerst reg", freq_control_reg, 16'h0102);
    chk("rerst pll", {15'h0, main_multiplier_pll_on}, 16'h0000);
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    settle();
    verify(16'h0102);
    stop_test();
  end
endmodule // clock_ratio_generator_tb
